// File: common/rtt_pkg.sv
// package for the register transfer, trap and zero test execution unit
// assumes a 16-bit core with a separate fetch unit that supplies opcodes and operands
`default_nettype none

package rtt_pkg;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_TRANSFER = 8'hb7;
  localparam logic [7:0] OP_MEM_TEST_EXT = 8'hf7;
  localparam logic [7:0] OP_MEM_TEST_IDX = 8'he7;
  localparam logic [7:0] OP_ACC_A_TEST = 8'h97;
  localparam logic [7:0] OP_PAGE2_PREFIX = 8'h18;
  localparam logic [7:0] FLAGS_TO_ACC_A_POSTBYTE = 8'h20;
  localparam logic [7:0] TRAP_LOW_FIRST = 8'h30;
  localparam logic [7:0] TRAP_LOW_LAST = 8'h39;
  localparam logic [7:0] TRAP_HIGH_FIRST = 8'h40;
  localparam logic [7:0] TRAP_HIGH_LAST = 8'hff;

  // ----------------------------------------
  // register select codes of the transfer postbyte
  // ----------------------------------------
  localparam logic [2:0] SEL_A = 3'h0;
  localparam logic [2:0] SEL_B = 3'h1;
  localparam logic [2:0] SEL_CCR = 3'h2;
  localparam logic [2:0] SEL_TEMP = 3'h3;
  localparam logic [2:0] SEL_D = 3'h4;
  localparam logic [2:0] SEL_X = 3'h5;
  localparam logic [2:0] SEL_Y = 3'h6;
  localparam logic [2:0] SEL_SP = 3'h7;

  // ----------------------------------------
  // condition code layout: S X H I N Z V C
  // ----------------------------------------
  localparam int CCR_X_BIT = 6;
  localparam int CCR_I_BIT = 4;
  localparam int CCR_N_BIT = 3;
  localparam int CCR_Z_BIT = 2;
  localparam int CCR_V_BIT = 1;
  localparam int CCR_C_BIT = 0;

  // ----------------------------------------
  // reset values, stack and vector
  // ----------------------------------------
  localparam logic [7:0] CCR_RESET = 8'hd0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] TRAP_VECTOR_ADDR = 16'hfff8;
  localparam logic [15:0] STACK_WORD_STEP = 16'h0002;
  localparam logic [15:0] STACK_BYTE_STEP = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH_RTN,
    ST_PUSH_Y,
    ST_PUSH_X,
    ST_PUSH_BA,
    ST_PUSH_CCR,
    ST_VECTOR
  } rtt_state_type;

endpackage

`default_nettype wire

// File: rtl/rtt_xfer_src.sv
// source side of the register transfer: picks the source and widens it
// assumes the caller decides how many bytes of the result the destination keeps
`default_nettype none
`timescale 1ns/1ps

module rtt_xfer_src (
  input wire logic [3:0] src_code_in,
  input wire logic [7:0] acc_a_in,
  input wire logic [7:0] acc_b_in,
  input wire logic [7:0] ccr_in,
  input wire logic [15:0] temp_three_in,
  input wire logic [15:0] index_x_in,
  input wire logic [15:0] index_y_in,
  input wire logic [15:0] stack_ptr_in,
  output logic [15:0] src_value_out
);

  function automatic logic [15:0] sign_extend(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // the top bit of the source nibble is not part of the code
  always_comb begin
    unique case (src_code_in[2:0])
      rtt_pkg::SEL_A: src_value_out = sign_extend(acc_a_in);
      rtt_pkg::SEL_B: src_value_out = sign_extend(acc_b_in);
      rtt_pkg::SEL_CCR: src_value_out = sign_extend(ccr_in);
      rtt_pkg::SEL_TEMP: src_value_out = temp_three_in;
      rtt_pkg::SEL_D: src_value_out = {acc_a_in, acc_b_in};
      rtt_pkg::SEL_X: src_value_out = index_x_in;
      rtt_pkg::SEL_Y: src_value_out = index_y_in;
      rtt_pkg::SEL_SP: src_value_out = stack_ptr_in;
    endcase
  end

endmodule // rtt_xfer_src

`default_nettype wire

// File: rtl/rtt_exec.sv
// execution unit for register transfer, flags-to-A alias, opcode trap and zero tests
// assumes a fetch unit that presents one decoded instruction with its operand byte
// and the address after it, and a memory that answers each request with an ack
//
// Notes on behaviour
// - opcode b7 postbyte high nibble picks source
// - low nibble picks destination, its msb ignored
// - byte source into word gets sign extended
// - word into byte keeps low byte only
// - transfer keeps flags unless flags are destination
// - flags destination copies bits, X never rises
// - X set only by reset or nonmaskable
// - hidden temporary codes still execute as transfers
// - b7 20 copies flags into A unchanged
// - page two unimplemented opcodes raise trap
// - trap range 30-39 and 40-ff
// - return address follows the unimplemented opcode
// - stack return, Y, X, B:A, flags in order
// - after stacking set I, jump vector
// - trap taken whatever the I mask
`default_nettype none
`timescale 1ns/1ps

module rtt_exec (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic PAGE2_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [7:0] TRANSFER_POSTBYTE_IN,
  input wire logic [7:0] MEM_OPERAND_IN,
  input wire logic [15:0] NEXT_PC_IN,
  input wire logic NONMASKABLE_IRQ_TAKEN_IN,
  input wire logic LOAD_VALID_IN,
  input wire logic [2:0] LOAD_SEL_IN,
  input wire logic [15:0] LOAD_DATA_IN,
  input wire logic MEM_ACK_IN,
  input wire logic [15:0] MEM_RDATA_IN,
  output logic INSTR_READY_OUT,
  output logic MEM_REQ_OUT,
  output logic MEM_WRITE_OUT,
  output logic MEM_BYTE_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  output logic [15:0] MEM_WDATA_OUT,
  output logic [7:0] ACC_A_OUT,
  output logic [7:0] ACC_B_OUT,
  output logic [7:0] CONDITION_CODE_REG_OUT,
  output logic [15:0] INDEX_X_OUT,
  output logic [15:0] INDEX_Y_OUT,
  output logic [15:0] STACK_PTR_OUT,
  output logic [15:0] PROGRAM_COUNTER_OUT,
  output logic [15:0] HIDDEN_TEMP_TWO_OUT,
  output logic [15:0] HIDDEN_TEMP_THREE_OUT
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rtt_pkg::rtt_state_type state, next_state;
  logic ready, next_ready;
  logic [7:0] acc_a, next_acc_a, acc_b, next_acc_b, condition_code_reg, next_ccr;
  logic [15:0] idx_x, next_idx_x, idx_y, next_idx_y, sp, next_sp, pc, next_pc;
  logic [15:0] temp_two, next_temp_two, temp_three;
  logic mem_req, next_mem_req, mem_we, next_mem_we, mem_byte, next_mem_byte;
  logic [15:0] mem_addr, next_mem_addr, mem_wdata, next_mem_wdata;
  logic [15:0] xfer_src;
  logic accept;
  logic is_trap;

  rtt_xfer_src u_src (
    .src_code_in(TRANSFER_POSTBYTE_IN[7:4]),
    .acc_a_in(acc_a),
    .acc_b_in(acc_b),
    .ccr_in(condition_code_reg),
    .temp_three_in(temp_three),
    .index_x_in(idx_x),
    .index_y_in(idx_y),
    .stack_ptr_in(sp),
    .src_value_out(xfer_src)
  );

  function automatic logic trap_opcode_byte(input logic [7:0] op);
    return ((op >= rtt_pkg::TRAP_LOW_FIRST) && (op <= rtt_pkg::TRAP_LOW_LAST)) ||
           ((op >= rtt_pkg::TRAP_HIGH_FIRST) && (op <= rtt_pkg::TRAP_HIGH_LAST));
  endfunction

  // zero test: subtracting zero leaves the value, so only the flags move
  function automatic logic [7:0] zero_test_flags(input logic [7:0] flags, input logic [7:0] v);
    logic [7:0] f;
    f = flags;
    f[rtt_pkg::CCR_N_BIT] = v[7];
    f[rtt_pkg::CCR_Z_BIT] = (v == 8'h00);
    f[rtt_pkg::CCR_V_BIT] = 1'b0;
    f[rtt_pkg::CCR_C_BIT] = 1'b0;
    return f;
  endfunction

  assign accept = INSTR_VALID_IN && ready;
  assign is_trap = PAGE2_IN && trap_opcode_byte(OPCODE_IN);

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_ccr = condition_code_reg;
    next_idx_x = idx_x;
    next_idx_y = idx_y;
    next_sp = sp;
    next_pc = pc;
    next_temp_two = temp_two;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_byte = mem_byte;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;

    unique case (state)
      rtt_pkg::ST_IDLE: begin
        if (accept) begin
          next_pc = NEXT_PC_IN;
          if (is_trap) begin
            // the I mask is not consulted here at all
            next_sp = sp - rtt_pkg::STACK_WORD_STEP;
            next_mem_req = 1'b1;
            next_mem_we = 1'b1;
            next_mem_byte = 1'b0;
            next_mem_addr = sp - rtt_pkg::STACK_WORD_STEP;
            next_mem_wdata = NEXT_PC_IN;
            next_state = rtt_pkg::ST_PUSH_RTN;
          end else if (!PAGE2_IN && OPCODE_IN == rtt_pkg::OP_TRANSFER) begin
            // single cycle, no memory traffic; b7 20 lands here as flags into A
            unique case (TRANSFER_POSTBYTE_IN[2:0])
              rtt_pkg::SEL_A: next_acc_a = xfer_src[7:0];
              rtt_pkg::SEL_B: next_acc_b = xfer_src[7:0];
              rtt_pkg::SEL_CCR: begin
                next_ccr = xfer_src[7:0];
                next_ccr[rtt_pkg::CCR_X_BIT] = xfer_src[rtt_pkg::CCR_X_BIT] & condition_code_reg[rtt_pkg::CCR_X_BIT];
              end
              rtt_pkg::SEL_TEMP: next_temp_two = xfer_src;
              rtt_pkg::SEL_D: begin
                next_acc_a = xfer_src[15:8];
                next_acc_b = xfer_src[7:0];
              end
              rtt_pkg::SEL_X: next_idx_x = xfer_src;
              rtt_pkg::SEL_Y: next_idx_y = xfer_src;
              rtt_pkg::SEL_SP: next_sp = xfer_src;
            endcase
          end else if (!PAGE2_IN && (OPCODE_IN == rtt_pkg::OP_MEM_TEST_EXT ||
                                     OPCODE_IN == rtt_pkg::OP_MEM_TEST_IDX)) begin
            next_ccr = zero_test_flags(condition_code_reg, MEM_OPERAND_IN);
          end else if (!PAGE2_IN && OPCODE_IN == rtt_pkg::OP_ACC_A_TEST) begin
            next_ccr = zero_test_flags(condition_code_reg, acc_a);
          end
        end else if (LOAD_VALID_IN) begin
          unique case (LOAD_SEL_IN)
            rtt_pkg::SEL_A: next_acc_a = LOAD_DATA_IN[7:0];
            rtt_pkg::SEL_B: next_acc_b = LOAD_DATA_IN[7:0];
            rtt_pkg::SEL_CCR: begin
              next_ccr = LOAD_DATA_IN[7:0];
              next_ccr[rtt_pkg::CCR_X_BIT] = LOAD_DATA_IN[rtt_pkg::CCR_X_BIT] & condition_code_reg[rtt_pkg::CCR_X_BIT];
            end
            rtt_pkg::SEL_TEMP: next_temp_two = LOAD_DATA_IN;
            rtt_pkg::SEL_D: begin
              next_acc_a = LOAD_DATA_IN[15:8];
              next_acc_b = LOAD_DATA_IN[7:0];
            end
            rtt_pkg::SEL_X: next_idx_x = LOAD_DATA_IN;
            rtt_pkg::SEL_Y: next_idx_y = LOAD_DATA_IN;
            rtt_pkg::SEL_SP: next_sp = LOAD_DATA_IN;
          endcase
        end
      end
      rtt_pkg::ST_PUSH_RTN: begin
        if (MEM_ACK_IN) begin
          next_sp = sp - rtt_pkg::STACK_WORD_STEP;
          next_mem_addr = sp - rtt_pkg::STACK_WORD_STEP;
          next_mem_wdata = idx_y;
          next_state = rtt_pkg::ST_PUSH_Y;
        end
      end
      rtt_pkg::ST_PUSH_Y: begin
        if (MEM_ACK_IN) begin
          next_sp = sp - rtt_pkg::STACK_WORD_STEP;
          next_mem_addr = sp - rtt_pkg::STACK_WORD_STEP;
          next_mem_wdata = idx_x;
          next_state = rtt_pkg::ST_PUSH_X;
        end
      end
      rtt_pkg::ST_PUSH_X: begin
        if (MEM_ACK_IN) begin
          next_sp = sp - rtt_pkg::STACK_WORD_STEP;
          next_mem_addr = sp - rtt_pkg::STACK_WORD_STEP;
          next_mem_wdata = {acc_b, acc_a};
          next_state = rtt_pkg::ST_PUSH_BA;
        end
      end
      rtt_pkg::ST_PUSH_BA: begin
        if (MEM_ACK_IN) begin
          next_sp = sp - rtt_pkg::STACK_BYTE_STEP;
          next_mem_addr = sp - rtt_pkg::STACK_BYTE_STEP;
          next_mem_byte = 1'b1;
          next_mem_wdata = {8'h00, condition_code_reg};
          next_state = rtt_pkg::ST_PUSH_CCR;
        end
      end
      rtt_pkg::ST_PUSH_CCR: begin
        if (MEM_ACK_IN) begin
          next_mem_we = 1'b0;
          next_mem_byte = 1'b0;
          next_mem_addr = rtt_pkg::TRAP_VECTOR_ADDR;
          next_mem_wdata = rtt_pkg::WORD_RESET;
          next_state = rtt_pkg::ST_VECTOR;
        end
      end
      rtt_pkg::ST_VECTOR: begin
        if (MEM_ACK_IN) begin
          // I is set only once the flags have been stacked
          next_ccr[rtt_pkg::CCR_I_BIT] = 1'b1;
          next_pc = MEM_RDATA_IN;
          next_mem_req = 1'b0;
          next_state = rtt_pkg::ST_IDLE;
        end
      end
    endcase

    // a nonmaskable request taken in the same cycle as a flags write still sets X
    if (NONMASKABLE_IRQ_TAKEN_IN) begin
      next_ccr[rtt_pkg::CCR_X_BIT] = 1'b1;
    end
    next_ready = (next_state == rtt_pkg::ST_IDLE);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= rtt_pkg::ST_IDLE;
      ready <= 1'b1;
      acc_a <= rtt_pkg::BYTE_RESET;
      acc_b <= rtt_pkg::BYTE_RESET;
      condition_code_reg <= rtt_pkg::CCR_RESET;
      idx_x <= rtt_pkg::WORD_RESET;
      idx_y <= rtt_pkg::WORD_RESET;
      sp <= rtt_pkg::WORD_RESET;
      pc <= rtt_pkg::WORD_RESET;
      temp_two <= rtt_pkg::WORD_RESET;
      temp_three <= rtt_pkg::WORD_RESET;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= rtt_pkg::WORD_RESET;
      mem_wdata <= rtt_pkg::WORD_RESET;
    end else begin
      state <= next_state;
      ready <= next_ready;
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      condition_code_reg <= next_ccr;
      idx_x <= next_idx_x;
      idx_y <= next_idx_y;
      sp <= next_sp;
      pc <= next_pc;
      temp_two <= next_temp_two;
      // hidden temp three has no writer in this unit; it only feeds transfers
      temp_three <= temp_three;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_byte <= next_mem_byte;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  assign INSTR_READY_OUT = ready;
  assign MEM_REQ_OUT = mem_req;
  assign MEM_WRITE_OUT = mem_we;
  assign MEM_BYTE_OUT = mem_byte;
  assign MEM_ADDR_OUT = mem_addr;
  assign MEM_WDATA_OUT = mem_wdata;
  assign ACC_A_OUT = acc_a;
  assign ACC_B_OUT = acc_b;
  assign CONDITION_CODE_REG_OUT = condition_code_reg;
  assign INDEX_X_OUT = idx_x;
  assign INDEX_Y_OUT = idx_y;
  assign STACK_PTR_OUT = sp;
  assign PROGRAM_COUNTER_OUT = pc;
  assign HIDDEN_TEMP_TWO_OUT = temp_two;
  assign HIDDEN_TEMP_THREE_OUT = temp_three;

endmodule // rtt_exec

`default_nettype wire

// File: tb/rtt_exec_checker.sv
// concurrent checks for the transfer, trap and zero test unit
// assumes it is bound to rtt_exec and sees only that module's ports
`default_nettype none
`timescale 1ns/1ps
module rtt_exec_checker (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic PAGE2_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [7:0] TRANSFER_POSTBYTE_IN,
  input wire logic [7:0] MEM_OPERAND_IN,
  input wire logic [15:0] NEXT_PC_IN,
  input wire logic NONMASKABLE_IRQ_TAKEN_IN,
  input wire logic MEM_ACK_IN,
  input wire logic [15:0] MEM_RDATA_IN,
  input wire logic INSTR_READY_OUT,
  input wire logic MEM_REQ_OUT,
  input wire logic MEM_WRITE_OUT,
  input wire logic [15:0] MEM_ADDR_OUT,
  input wire logic [15:0] MEM_WDATA_OUT,
  input wire logic [7:0] ACC_A_OUT,
  input wire logic [7:0] CONDITION_CODE_REG_OUT,
  input wire logic [15:0] STACK_PTR_OUT,
  input wire logic [15:0] PROGRAM_COUNTER_OUT
);
  logic go, p1, trap_go, xfer_go;
  logic [7:0] cc;
  assign cc = CONDITION_CODE_REG_OUT;
  assign go = INSTR_VALID_IN && INSTR_READY_OUT;
  assign p1 = go && !PAGE2_IN && !NONMASKABLE_IRQ_TAKEN_IN;
  assign trap_go = go && PAGE2_IN && (OPCODE_IN[7:6] != 2'h0 || (OPCODE_IN[7:4] == 4'h3 && OPCODE_IN[3:0] <= 4'h9));
  assign xfer_go = p1 && OPCODE_IN == rtt_pkg::OP_TRANSFER;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_push;
    MEM_REQ_OUT && MEM_WRITE_OUT && !INSTR_READY_OUT;
  endsequence
  sequence s_back;
    INSTR_READY_OUT && !MEM_REQ_OUT && cc[4];
  endsequence
  a_trap_push_rtn: assert property (trap_go |=> s_push ##0 (MEM_ADDR_OUT == $past(STACK_PTR_OUT) - 16'h0002
    && MEM_WDATA_OUT == $past(NEXT_PC_IN))) else $error("trap did not push the return address");
  a_trap_vector_addr: assert property (MEM_REQ_OUT && !MEM_WRITE_OUT |-> MEM_ADDR_OUT == 16'hfff8)
    else $error("vector read at wrong address");
  a_trap_resume: assert property (MEM_REQ_OUT && !MEM_WRITE_OUT && MEM_ACK_IN |=> s_back
    ##0 PROGRAM_COUNTER_OUT == $past(MEM_RDATA_IN)) else $error("trap did not resume at vector");
  a_req_holds: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT)
    && $stable(MEM_WDATA_OUT)) else $error("memory request changed before ack");
  a_x_no_rise: assert property ($rose(cc[6]) |-> $past(NONMASKABLE_IRQ_TAKEN_IN))
    else $error("X mask rose without nonmaskable request");
  a_xfer_keeps_flags: assert property (xfer_go && TRANSFER_POSTBYTE_IN[2:0] != rtt_pkg::SEL_CCR
    |=> $stable(cc) && INSTR_READY_OUT && !MEM_REQ_OUT) else $error("transfer disturbed flags or stalled");
  a_flags_to_a: assert property (xfer_go && TRANSFER_POSTBYTE_IN == 8'h20 |=> ACC_A_OUT == $past(cc)
    && $stable(cc)) else $error("flags to A alias wrong");
  a_test_a_flags: assert property (p1 && OPCODE_IN == rtt_pkg::OP_ACC_A_TEST |=> $stable(ACC_A_OUT)
    && cc == {$past(cc[7:4]), $past(ACC_A_OUT[7]), $past(ACC_A_OUT) == 8'h00, 2'h0}) else $error("test A wrong");
  a_mem_test_flags: assert property (p1 && OPCODE_IN[7:5] == 3'h7 && OPCODE_IN[3:0] == 4'h7 |=> !MEM_REQ_OUT
    && cc[3:0] == {$past(MEM_OPERAND_IN[7]), $past(MEM_OPERAND_IN) == 8'h00, 2'h0}) else $error("memory test wrong");
endmodule // rtt_exec_checker
bind rtt_exec rtt_exec_checker chk (.CORE_CLK_IN, .RESET_N_IN, .INSTR_VALID_IN, .PAGE2_IN, .OPCODE_IN,
  .TRANSFER_POSTBYTE_IN, .MEM_OPERAND_IN, .NEXT_PC_IN, .NONMASKABLE_IRQ_TAKEN_IN, .MEM_ACK_IN, .MEM_RDATA_IN,
  .INSTR_READY_OUT, .MEM_REQ_OUT, .MEM_WRITE_OUT, .MEM_ADDR_OUT, .MEM_WDATA_OUT, .ACC_A_OUT,
  .CONDITION_CODE_REG_OUT, .STACK_PTR_OUT, .PROGRAM_COUNTER_OUT);
`default_nettype wire

// File: tb/rtt_mem_model.sv
// system memory model answering stack writes and the vector read
// assumes requests hold until ack; words are high byte first
`default_nettype none
`timescale 1ns/1ps
module rtt_mem_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic byte_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [3:0] delay_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;
  // plain always: the bench preloads the vector bytes into this array at time zero
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdata_out <= 16'h5a5a;
    end else begin
      ack_out <= 1'b0;
      // data lines idle: toggle so a stale read never looks right
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
        cnt <= cnt + 4'h1;
        if (cnt >= delay_in) begin
          cnt <= 4'h0;
          ack_out <= 1'b1;
          if (!write_in) rdata_out <= {mem[addr_in], mem[addr_in + 16'h0001]};
          else if (byte_in) mem[addr_in] <= wdata_in[7:0];
          else begin
            mem[addr_in] <= wdata_in[15:8];
            mem[addr_in + 16'h0001] <= wdata_in[7:0];
          end
        end
      end
    end
  end
endmodule // rtt_mem_model
`default_nettype wire

// File: tb/tb_register_transfer_trap_test.sv
// random and corner stimulus for the transfer, trap and zero test unit
// assumes the memory model sits on the memory port and holds the vector
`default_nettype none
`timescale 1ns/1ps
module tb_register_transfer_trap_test;
  logic clk, rst_n, iv, p2, nmi, lv, req, wr, bt, ack, rdy, tr;
  logic [7:0] op, pb, mop, a_o, b_o, cc_o, a, b, cc, p, o, v8;
  logic [15:0] npc, ld, addr, wd, rd, x_o, y_o, sp_o, pc_o, t2_o, t3_o, x, y, sp, t2;
  logic [2:0] ls, k;
  logic [3:0] dly;
  logic [31:0] seed = 32'd88255;
  logic [7:0] corner [7] = '{8'h20, 8'h02, 8'h32, 8'h04, 8'h40, 8'h23, 8'h3c};
  int fails, samples_checked;
  rtt_exec DUT (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .INSTR_VALID_IN(iv), .PAGE2_IN(p2), .OPCODE_IN(op),
    .TRANSFER_POSTBYTE_IN(pb), .MEM_OPERAND_IN(mop), .NEXT_PC_IN(npc), .NONMASKABLE_IRQ_TAKEN_IN(nmi),
    .LOAD_VALID_IN(lv), .LOAD_SEL_IN(ls), .LOAD_DATA_IN(ld), .MEM_ACK_IN(ack), .MEM_RDATA_IN(rd),
    .INSTR_READY_OUT(rdy), .MEM_REQ_OUT(req), .MEM_WRITE_OUT(wr), .MEM_BYTE_OUT(bt), .MEM_ADDR_OUT(addr),
    .MEM_WDATA_OUT(wd), .ACC_A_OUT(a_o), .ACC_B_OUT(b_o), .CONDITION_CODE_REG_OUT(cc_o), .INDEX_X_OUT(x_o),
    .INDEX_Y_OUT(y_o), .STACK_PTR_OUT(sp_o), .PROGRAM_COUNTER_OUT(pc_o), .HIDDEN_TEMP_TWO_OUT(t2_o),
    .HIDDEN_TEMP_THREE_OUT(t3_o));
  rtt_mem_model mem_i (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .write_in(wr), .byte_in(bt),
    .addr_in(addr), .wdata_in(wd), .delay_in(dly), .ack_out(ack), .rdata_out(rd));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] src(input logic [2:0] s);
    case (s)
      3'h0: return {{8{a[7]}}, a};
      3'h1: return {{8{b[7]}}, b};
      3'h2: return {{8{cc[7]}}, cc};
      3'h3: return 16'h0000;
      3'h4: return {a, b};
      3'h5: return x;
      3'h6: return y;
      default: return sp;
    endcase
  endfunction
  task automatic put(input logic [2:0] s, input logic [15:0] d);
    case (s)
      3'h0: a = d[7:0];
      3'h1: b = d[7:0];
      3'h2: cc = {d[7], cc[6] & d[6], d[5:0]};
      3'h3: t2 = d;
      3'h4: {a, b} = d;
      3'h5: x = d;
      3'h6: y = d;
      default: sp = d;
    endcase
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk_regs();
    chk({a_o, b_o}, {a, b});
    chk({cc_o, 8'h00}, {cc, 8'h00});
    chk(x_o, x);
    chk(y_o, y);
    chk(sp_o, sp);
    chk(t2_o, t2);
    chk(t3_o, 16'h0000);
  endtask
  task automatic load(input logic [2:0] s, input logic [15:0] d, input logic n);
    iv = 1'b0;
    lv = 1'b1;
    nmi = n;
    ls = s;
    ld = d;
    @(negedge clk);
    put(s, d);
    if (n) cc[6] = 1'b1;
  endtask
  task automatic issue(input logic pg, input logic [7:0] oc, input logic [7:0] pbv, input logic [7:0] m);
    lv = 1'b0;
    nmi = 1'b0;
    iv = 1'b1;
    p2 = pg;
    op = oc;
    pb = pbv;
    mop = m;
    npc = rnd();
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    {rst_n, iv, p2, nmi, lv, op, pb, mop, npc, ls, ld, dly} = '0;
    {a, b, x, y, sp, t2} = '0;
    cc = 8'hd0;
    mem_i.mem[16'hfff8] = 8'hc1;
    mem_i.mem[16'hfff9] = 8'h23;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk_regs();
    for (int i = 0; i < 300; i++) begin
      k = 3'(rnd());
      load(k, rnd(), i % 16 == 5);
      p = (i < 7) ? corner[i] : {1'b0, 7'(rnd())};
      issue(1'b0, rtt_pkg::OP_TRANSFER, p, 8'h00);
      put(p[2:0], src(p[6:4]));
      chk_regs();
      chk(pc_o, npc);
    end
    $display("transfer test done");
    for (int i = 0; i < 40; i++) begin
      v8 = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'h7f : 8'(rnd());
      load(3'h0, {8'h00, v8}, 1'b0);
      issue(1'b0, rtt_pkg::OP_ACC_A_TEST, 8'h00, 8'h00);
      cc = {cc[7:4], v8[7], v8 == 8'h00, 2'h0};
      chk_regs();
      issue(1'b0, i[0] ? rtt_pkg::OP_MEM_TEST_EXT : rtt_pkg::OP_MEM_TEST_IDX, 8'h00, ~v8);
      cc = {cc[7:4], ~v8[7], v8 == 8'hff, 2'h0};
      chk_regs();
      chk({15'h0000, req}, 16'h0000);
    end
    $display("zero test done");
    for (int i = 0; i < 12; i++) begin
      dly = 4'(i % 4);
      load(3'h7, {1'b0, 15'(rnd())} + 16'h0010, 1'b0);
      load(3'h2, rnd(), 1'b0);
      o = (i < 4) ? corner[i] | 8'h30 : (i < 10) ? 8'h40 | 8'(rnd()) : (i == 10) ? 8'h2f : 8'h3a;
      if (i == 1) o = 8'h39;
      if (i == 3) o = 8'hff;
      tr = o[7:6] != 2'h0 || (o[7:4] == 4'h3 && o[3:0] <= 4'h9);
      issue(1'b1, o, 8'h00, 8'h00);
      iv = 1'b0;
      for (int n = 0; n < 100 && rdy !== 1'b1; n++) @(negedge clk);
      if (tr) begin
        chk({mem_i.mem[sp - 16'h0002], mem_i.mem[sp - 16'h0001]}, npc);
        chk({mem_i.mem[sp - 16'h0004], mem_i.mem[sp - 16'h0003]}, y);
        chk({mem_i.mem[sp - 16'h0006], mem_i.mem[sp - 16'h0005]}, x);
        chk({mem_i.mem[sp - 16'h0008], mem_i.mem[sp - 16'h0007]}, {b, a});
        chk({8'h00, mem_i.mem[sp - 16'h0009]}, {8'h00, cc});
        sp = sp - 16'h0009;
        cc[4] = 1'b1;
      end
      chk(pc_o, tr ? 16'hc123 : npc);
      chk_regs();
    end
    $display("trap test done");
    stop_test();
  end
endmodule // tb_register_transfer_trap_test
`default_nettype wire
